// ---- core/burst_preamble_pc_readout.sv ----
// preamble word capture and serial readout, with update and sync status
// Summary of operation
// R01 - the captured preamble word is readable by the host as a register.
// R02 - a read of the preamble register shifts out all sixteen bits, least significant first.
// R03 - the host selects the preamble register by first sending its readout address.
// R04 - bits zero to four carry the data type code, zero for null data and three for pause.
// R05 - bits five and six are reserved and returned exactly as received.
// R06 - bit seven is the payload error flag, one meaning the burst payload holds errors.
// R07 - bits eight to twelve carry the type-dependent information unchanged.
// R08 - bits thirteen to fifteen carry the bit-stream number as received.
// R09 - a status flag is set on each new preamble word and cleared once the host reads status.
// R10 - a status bit reports whether the burst sync preambles have been detected.
// R11 - the preamble word stays frozen while a readout frame is in progress.
`timescale 1ns/1ns
module burst_preamble_pc_readout (
   // core clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // demodulator side, core clock
   input wire pc_readout_pkg::pc_word_s i_pc_word,
   input wire logic i_pc_valid,
   input wire logic i_burst_sync_detected,
   // serial control link
   input wire logic i_sclk,
   input wire logic i_ce,
   input wire logic i_sdi,
   output logic o_sdo,
   output logic o_sdo_oe,
   // live status for the rest of the chip
   output logic o_preamble_update_flag
);
   // ---------------- core domain ----------------
   logic frame_s;
   logic read_tog;
   logic read_s;
   logic read_d;
   logic read_evt;
   pc_readout_pkg::pc_word_s pc_latest;
   pc_readout_pkg::pc_word_s pc_shadow;
   logic update_flag;
   logic next_update_flag;
   logic flag_snap;
   logic sync_live;
   logic sync_snap;

   level_sync #(.STAGES(2)) u_frame_sync (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_level(i_ce),
      .o_level(frame_s)
   );

   level_sync #(.STAGES(2)) u_read_sync (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_level(read_tog),
      .o_level(read_s)
   );

   // status read arrives as a toggle; an edge means one read completed its address phase
   assign read_evt = read_s ^ read_d;
   // a new word in the same cycle as the clear keeps the flag set
   assign next_update_flag = i_pc_valid ? 1'b1 : (read_evt ? 1'b0 : update_flag); // see R09

   // newest word always lands in pc_latest; words arriving mid-frame are not lost
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pc_latest <= pc_readout_pkg::PC_RESET;
      end else if (i_pc_valid) begin
         pc_latest <= i_pc_word; // see R01
      end
   end

   // snapshots only move outside a frame, so the link reads them as quasi-static
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pc_shadow <= pc_readout_pkg::PC_RESET;
         flag_snap <= 1'b0;
         sync_snap <= 1'b0;
      end else if (!frame_s) begin
         pc_shadow <= pc_latest; // see R11
         flag_snap <= update_flag;
         sync_snap <= sync_live; // see R10
      end
   end

   // flag, sync level and toggle edge detector
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         update_flag <= 1'b0;
         sync_live <= 1'b0;
         read_d <= 1'b0;
      end else begin
         update_flag <= next_update_flag;
         sync_live <= i_burst_sync_detected;
         read_d <= read_s;
      end
   end

   assign o_preamble_update_flag = update_flag;

   // ---------------- link domain ----------------
   // frame end clears the link side, since the serial clock stops between frames
   logic link_rst_n;
   pc_readout_pkg::link_state_e state;
   logic [4:0] cnt;
   logic [7:0] addr;
   logic [23:0] shift;
   logic [7:0] addr_full;
   logic addr_done;
   logic sel_pc;
   logic sel_status;
   logic [23:0] status_word;
   logic [23:0] pc_load;

   assign link_rst_n = i_reset_n & i_ce;
   assign addr_full = {i_sdi, addr[7:1]}; // address arrives lsb first
   assign addr_done = (state == pc_readout_pkg::ST_ADDR) && (cnt == pc_readout_pkg::CNT_ADDR_LAST);
   assign sel_pc = addr_done && (addr_full == pc_readout_pkg::ADDR_PC_WORD); // see R03
   assign sel_status = addr_done && (addr_full == pc_readout_pkg::ADDR_STATUS);
   // all five fields are passed as received, reserved bits included
   assign pc_load = {{(pc_readout_pkg::STATUS_BITS - pc_readout_pkg::PC_BITS){1'b0}},
                     pc_shadow}; // see R04 R05 R06 R07 R08
   assign status_word = (24'(flag_snap) << pc_readout_pkg::STATUS_UPDATE_POS)
                      | (24'(sync_snap) << pc_readout_pkg::STATUS_SYNC_POS); // see R10
   assign o_sdo = shift[0];
   assign o_sdo_oe = (state == pc_readout_pkg::ST_DATA);

   // address phase, then lsb-first shift of the selected word
   always_ff @(posedge i_sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         state <= pc_readout_pkg::ST_ADDR;
         cnt <= pc_readout_pkg::CNT_ZERO;
         addr <= 8'h00;
         shift <= pc_readout_pkg::SHIFT_RESET;
      end else begin
         case (state)
            pc_readout_pkg::ST_ADDR: begin
               addr <= addr_full;
               cnt <= cnt + 5'h01;
               if (addr_done) begin
                  if (sel_pc) begin
                     shift <= pc_load; // see R02
                     cnt <= pc_readout_pkg::CNT_PC_LOAD;
                     state <= pc_readout_pkg::ST_DATA;
                  end else if (sel_status) begin
                     shift <= status_word;
                     cnt <= pc_readout_pkg::CNT_STATUS_LOAD;
                     state <= pc_readout_pkg::ST_DATA;
                  end else begin
                     state <= pc_readout_pkg::ST_DONE; // unmapped address: stay silent
                  end
               end
            end
            pc_readout_pkg::ST_DATA: begin
               shift <= {1'b0, shift[23:1]}; // see R02
               cnt <= cnt - 5'h01;
               if (cnt == pc_readout_pkg::CNT_ZERO) begin
                  state <= pc_readout_pkg::ST_DONE;
               end
            end
            default: begin
               state <= pc_readout_pkg::ST_DONE;
            end
         endcase
      end
   end

   // the toggle survives frame ends, so it uses the plain reset
   always_ff @(posedge i_sclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         read_tog <= 1'b0;
      end else if (i_ce && sel_status) begin
         read_tog <= ~read_tog; // see R09
      end
   end

   // ---------------- assertions ----------------
   sequence s_word_taken;
      i_pc_valid ##1 !frame_s;
   endsequence

   property p_capture;
      @(posedge i_clk) disable iff (!i_reset_n)
      s_word_taken |=> (pc_shadow == $past(i_pc_word, 2));
   endproperty
   a_capture: assert property (p_capture) else $error("preamble word not captured"); // see R01

   property p_type_code;
      @(posedge i_clk) disable iff (!i_reset_n)
      s_word_taken |=> (pc_shadow.data_type == $past(i_pc_word.data_type, 2));
   endproperty
   a_type_code: assert property (p_type_code) else $error("data type code altered"); // see R04

   property p_reserved;
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_pc_valid && !frame_s) ##1 !frame_s |=> (pc_shadow.reserved == $past(i_pc_word.reserved, 2));
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits altered"); // see R05

   property p_error_bit;
      @(posedge i_clk) disable iff (!i_reset_n)
      s_word_taken ##1 1'b1 |-> (pc_shadow.payload_error == $past(i_pc_word.payload_error, 2));
   endproperty
   a_error_bit: assert property (p_error_bit) else $error("payload error flag altered"); // see R06

   property p_type_info;
      @(posedge i_clk) disable iff (!i_reset_n)
      s_word_taken |=> (pc_shadow.type_info == $past(i_pc_word.type_info, 2));
   endproperty
   a_type_info: assert property (p_type_info) else $error("type information altered"); // see R07

   property p_stream_number;
      @(posedge i_clk) disable iff (!i_reset_n)
      s_word_taken |=> (pc_shadow.bit_stream_number == $past(i_pc_word.bit_stream_number, 2));
   endproperty
   a_stream_number: assert property (p_stream_number) else $error("stream number altered"); // see R08

   property p_flag_set;
      @(posedge i_clk) disable iff (!i_reset_n)
      i_pc_valid |=> update_flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("update flag not set"); // see R09

   property p_flag_clear;
      @(posedge i_clk) disable iff (!i_reset_n)
      (read_evt && !i_pc_valid) |=> !update_flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("update flag not cleared on read"); // see R09

   property p_sync_bit;
      @(posedge i_clk) disable iff (!i_reset_n)
      (!frame_s && $past(!frame_s)) |-> (sync_snap == $past(i_burst_sync_detected, 2));
   endproperty
   a_sync_bit: assert property (p_sync_bit) else $error("sync status not reported"); // see R10

   property p_hold;
      @(posedge i_clk) disable iff (!i_reset_n)
      (frame_s && $past(frame_s)) |-> $stable(pc_shadow);
   endproperty
   a_hold: assert property (p_hold) else $error("preamble word moved during a frame"); // see R11

   property p_first_bit;
      @(posedge i_sclk) disable iff (!link_rst_n)
      sel_pc |=> (o_sdo_oe && (o_sdo == $past(pc_shadow[0])));
   endproperty
   a_first_bit: assert property (p_first_bit) else $error("readout does not start at bit zero"); // see R02

   // sixteen driven bits: the eighth mid-way, the last one as the counter runs out
   sequence s_sixteen_bits;
      o_sdo_oe [*8] ##0 (o_sdo == pc_shadow[7])
      ##1 o_sdo_oe [*8] ##0 ((o_sdo == pc_shadow[15]) && (cnt == pc_readout_pkg::CNT_ZERO));
   endsequence

   property p_length;
      @(posedge i_sclk) disable iff (!link_rst_n)
      sel_pc |=> s_sixteen_bits;
   endproperty
   a_length: assert property (p_length) else $error("readout is not sixteen bits long"); // see R02
endmodule

// ---- core/dummy_unused_never.sv ----
// no logic here; the block lives in the readout module and its synchroniser

// ---- core/level_sync.sv ----
// multi-stage synchroniser for a level crossing into the destination clock
`timescale 1ns/1ns
module level_sync #(
   parameter int STAGES = 2
) (
   // destination clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // level in and synchronised level out
   input wire logic i_level,
   output logic o_level
);
   logic [STAGES-1:0] chain;

   // fewer than two stages would let metastability reach the logic
   if (STAGES < 2) begin : g_stage_check
      $error("level_sync needs at least two stages");
   end

   // only the last stage is read outside this chain
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         chain <= '0;
      end else begin
         chain <= {chain[STAGES-2:0], i_level};
      end
   end

   assign o_level = chain[STAGES-1];
endmodule

// ---- core/pc_readout_pkg.sv ----
// shared constants, field layout and state encoding of the preamble readout block
package pc_readout_pkg;
   localparam int PC_BITS = 16;
   localparam int STATUS_BITS = 24;
   localparam int ADDR_BITS = 8;
   localparam int STATUS_UPDATE_POS = 13;
   localparam int STATUS_SYNC_POS = 17;
   localparam logic [7:0] ADDR_PC_WORD = 8'hed;
   localparam logic [7:0] ADDR_STATUS = 8'hea;
   localparam logic [4:0] CNT_ADDR_LAST = 5'h07;
   localparam logic [4:0] CNT_PC_LOAD = 5'h0f;
   localparam logic [4:0] CNT_STATUS_LOAD = 5'h17;
   localparam logic [4:0] CNT_ZERO = 5'h00;
   localparam logic [4:0] TYPE_NULL = 5'h00;
   localparam logic [4:0] TYPE_PAUSE = 5'h03;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [23:0] SHIFT_RESET = 24'h000000;

   // preamble word, msb first: stream number, type info, error, reserved, data type
   typedef struct packed {
      logic [2:0] bit_stream_number;
      logic [4:0] type_info;
      logic payload_error;
      logic [1:0] reserved;
      logic [4:0] data_type;
   } pc_word_s;

   typedef enum logic [1:0] {
      ST_ADDR = 2'b00,
      ST_DATA = 2'b01,
      ST_DONE = 2'b11
   } link_state_e;
endpackage

// ---- tb/serial_host_model.sv ----
// host model that frames serial readouts on the control link
`timescale 1ns/1ns
module serial_host_model (
   // link towards the device
   output logic o_sclk,
   output logic o_ce,
   output logic o_sdi,
   input wire logic i_sdo,
   input wire logic i_sdo_oe
);
   // the link clock stands low outside frames
   initial begin
      o_sclk = 1'b0;
      o_ce = 1'b0;
      o_sdi = 1'b0;
   end

   // one frame: 8 address bits lsb first, then data bits sampled before each rising edge
   task automatic read_frame(input logic [7:0] addr, input int nbits, output logic [23:0] data,
         output logic oe_held, output logic oe_after);
      data = 24'h000000;
      oe_held = 1'b1;
      o_ce = 1'b1;
      // ce settles well ahead of the eighth edge so the device snapshot is frozen
      #50;
      for (int i = 0; i < 8; i++) begin
         o_sdi = addr[i];
         #6 o_sclk = 1'b1;
         #6 o_sclk = 1'b0;
      end
      for (int k = 0; k < nbits; k++) begin
         data[k] = i_sdo_oe ? i_sdo : 1'b1; // a released line floats to the pull-up level
         oe_held = oe_held & i_sdo_oe;
         o_sdi = ~o_sdi; // unused in the data phase, keep it moving
         #6 o_sclk = 1'b1;
         #6 o_sclk = 1'b0;
      end
      oe_after = i_sdo_oe;
      o_ce = 1'b0;
      o_sdi = ~o_sdi;
      // gap between frames lets the link state reset
      #50;
   endtask
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the preamble word capture and serial readout
`timescale 1ns/1ns
module testbench;
   logic i_clk = 1'b0;
   logic i_reset_n;
   pc_readout_pkg::pc_word_s i_pc_word;
   logic i_pc_valid;
   logic i_burst_sync_detected;
   logic sclk;
   logic ce;
   logic sdi;
   logic o_sdo;
   logic o_sdo_oe;
   logic o_preamble_update_flag;
   logic [23:0] rd_data;
   logic held;
   logic after;
   int mismatches = 0;
   int n_tests = 0;
   // words cover null, pause, reserved codes 16, 26, 29, 31, error, reserved bits, info, stream
   logic [15:0] words [7] = '{16'h0000, 16'h0003, 16'h00e3, 16'hff10, 16'h1a9a, 16'h4a1f, 16'h1d1d};

   always #5 i_clk = ~i_clk;

   burst_preamble_pc_readout dut (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_pc_word(i_pc_word), .i_pc_valid(i_pc_valid),
      .i_burst_sync_detected(i_burst_sync_detected), .i_sclk(sclk), .i_ce(ce), .i_sdi(sdi),
      .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_preamble_update_flag(o_preamble_update_flag)
   );

   serial_host_model host (.o_sclk(sclk), .o_ce(ce), .o_sdi(sdi), .i_sdo(o_sdo), .i_sdo_oe(o_sdo_oe));

   // closing report, reached from the main sequence and from any exhausted wait
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check_val(input logic [23:0] exp, input logic [23:0] got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t expected %h got %h", $time, exp, got);
      end
   endtask

   task automatic check_bit(input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t expected %h got %h", $time, exp, got);
      end
   endtask

   // one-cycle capture pulse from the demodulator side
   task automatic push(input logic [15:0] w);
      @(posedge i_clk);
      i_pc_word <= w;
      i_pc_valid <= 1'b1;
      @(posedge i_clk);
      i_pc_valid <= 1'b0;
   endtask

   // bounded wait on the update flag; running out ends the run
   task automatic wait_flag(input logic exp);
      int n;
      n = 0;
      // step off the edge that may be launching the flag
      #1;
      while (o_preamble_update_flag !== exp && n < 20) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      check_bit(exp, o_preamble_update_flag);
      if (o_preamble_update_flag !== exp) wrap_up;
   endtask

   task automatic rd(input logic [7:0] addr, input int nbits);
      // start off the core clock edge, so the link phase is unrelated to it
      #3;
      host.read_frame(addr, nbits, rd_data, held, after);
   endtask

   initial begin
      i_reset_n = 1'b0;
      i_pc_word = 16'h0000;
      i_pc_valid = 1'b0;
      i_burst_sync_detected = 1'b0;
      repeat (2) @(posedge i_clk);
      i_reset_n <= 1'b1;
      @(posedge i_clk);
      #1;
      check_bit(1'b0, o_preamble_update_flag);
      rd(pc_readout_pkg::ADDR_STATUS, 24);
      check_val(24'h000000, rd_data);
      // every field passes through unchanged, lsb first
      foreach (words[i]) begin
         push(words[i]);
         wait_flag(1'b1);
         repeat (4) @(posedge i_clk);
         rd(pc_readout_pkg::ADDR_PC_WORD, 16);
         check_val({8'h00, words[i]}, rd_data);
         check_bit(1'b1, held);
         check_bit(1'b0, after);
      end
      // status shows the sync level and the flag, and the read clears the flag
      for (int s = 0; s < 2; s++) begin
         @(posedge i_clk);
         i_burst_sync_detected <= s[0];
         push(16'h0003);
         wait_flag(1'b1);
         repeat (4) @(posedge i_clk);
         rd(pc_readout_pkg::ADDR_STATUS, 24);
         check_val({6'h00, s[0], 3'h0, 1'b1, 13'h0000}, rd_data);
         wait_flag(1'b0);
      end
      // an address that selects nothing never turns the output on
      rd(8'heb, 16);
      check_bit(1'b0, held);
      check_val({8'h00, 16'hffff}, rd_data);
      check_bit(1'b0, after);
      // a word captured mid-frame does not disturb the frame in progress
      fork
         rd(pc_readout_pkg::ADDR_PC_WORD, 16);
         begin
            repeat (20) @(posedge i_clk);
            push(16'h5a85);
         end
      join
      check_val({8'h00, 16'h0003}, rd_data);
      rd(pc_readout_pkg::ADDR_PC_WORD, 16);
      check_val({8'h00, 16'h5a85}, rd_data);
      wrap_up;
   end
endmodule
